// ---- verilog/sdh_host_ctrl.sv ----
// Card bus host control: rates, command sequencing, interrupt window, suspend
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Extended status is fetched by CMD55 then CMD13, only when selected.
// - Data line 1 is sampled for interrupts only inside the interrupt window.
// - Card interrupt flag is cleared by a host write of a one to bit 0 of the status register.
// - Suspend/resume for functions 1 to 7 and memory, but not zero; resume any order.
// - Identify bus owner, suspend, confirm, run urgent transfer, then restore.
// - Read wait only in 1/4-bit mode, multiple read, capability checked, window.
// - Identification commands run open-drain at no more than 400 kHz.
// - Transfer mode may clock the card at up to 25 MHz.
// - GEN_CMD needs a selected card, block length from CMD16, R1b response; no CMD16 block length is tracked or checked here.
module sdh_host_ctrl (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cmdStart,
  output logic      [5:0]  cmdIndex,
  output logic             cmdResp1b,
  input  wire logic        cmdDone,
  input  wire logic        intWindow,
  input  wire logic        multiRead,
  input  wire logic        dat1In,
  output logic             dat2Out,
  output logic             dat2Oe,
  output logic             openDrain,
  output logic             cardClk,
  output logic      [7:0]  suspendReq,
  input  wire logic        suspendAck
);
  import sdh_pkg::*;

  logic [6:0] ctrl;
  logic       cardIrq;
  logic       refused;
  logic       rwActive;
  logic [8:1] suspended;
  logic       dat1Meta;
  logic       dat1Sync;
  logic       wrEn;
  logic       rdEn;
  logic       mapped;
  logic       cmdWr;
  logic       cmdOk;
  logic [5:0] reqIndex;
  logic       reqApp;
  logic       next_refused;
  logic [5:0] cmdIndexApp;
  sdh_seq_t   seq;

  function automatic logic isIdentCmd(input logic [5:0] idx, input logic app);
    isIdentCmd = (!app && (idx == 6'h00 || idx == 6'h01 || idx == 6'h02 ||
                  idx == 6'h03 || idx == 6'h05 || idx == 6'h28)) ||
                 (app && idx == IDX_OPCOND);
  endfunction

  function automatic logic needsSelect(input logic [5:0] idx, input logic app);
    needsSelect = (app && idx == IDX_STATUS) || (!app && idx == IDX_GEN);
  endfunction

  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
                  (paddr == OFS_STATUS) || (paddr == OFS_SUSP);
  assign wrEn   = psel && penable && pwrite && mapped;
  assign rdEn   = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign cmdWr  = wrEn && paddr == OFS_CMD;
  assign reqIndex = pwdata[5:0];
  assign reqApp   = pwdata[CMD_APP];
  assign cmdOk  = (seq == SEQ_IDLE) &&
                  !(needsSelect(reqIndex, reqApp) && !ctrl[CTRL_SELECT]) &&
                  !(isIdentCmd(reqIndex, reqApp) && ctrl[CTRL_XFER]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wrEn && paddr == OFS_CTRL) begin
      ctrl <= pwdata[6:0];
    end
  end

  // Identification runs slow and open-drain; transfer mode may go fast
  assign openDrain = !ctrl[CTRL_XFER];

  sdh_clk_div #(.W(DIV_W)) u_div (
    .clock     (clock),
    .rst       (rst),
    .run       (ctrl[CTRL_CLKRUN]),
    .halfCount (ctrl[CTRL_XFER] ? DIV_W'(XFER_HALF) : DIV_W'(ID_HALF)),
    .cardClk   (cardClk),
    .cardEdge  ()
  );

  // Application commands go out as APP_CMD then the index
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq       <= SEQ_IDLE;
      cmdStart  <= 1'b0;
      cmdIndex  <= '0;
      cmdResp1b <= 1'b0;
    end else begin
      cmdStart <= 1'b0;
      case (seq)
        SEQ_IDLE: begin
          if (cmdWr && cmdOk) begin
            cmdStart  <= 1'b1;
            cmdIndex  <= reqApp ? IDX_APP : reqIndex;
            cmdResp1b <= !reqApp && reqIndex == IDX_GEN;
            seq       <= reqApp ? SEQ_APP : SEQ_MAIN;
          end
        end
        SEQ_APP: begin
          if (cmdDone) begin
            cmdStart <= 1'b1;
            cmdIndex <= cmdIndexApp;
            seq      <= SEQ_MAIN;
          end
        end
        SEQ_MAIN: begin
          if (cmdDone) begin
            seq       <= SEQ_IDLE;
            cmdResp1b <= 1'b0;
          end
        end
        default: seq <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmdIndexApp <= '0;
    end else if (cmdWr && cmdOk) begin
      cmdIndexApp <= reqIndex;
    end
  end

  // Refusal is sticky; a new refusal beats the clear in the same cycle
  always_comb begin
    next_refused = refused;
    if (wrEn && paddr == OFS_STATUS && pwdata[ST_REFUSED]) begin
      next_refused = 1'b0;
    end
    if (cmdWr && !cmdOk) begin
      next_refused = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refused <= 1'b0;
    end else begin
      refused <= next_refused;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dat1Meta <= 1'b1;
      dat1Sync <= 1'b1;
    end else begin
      dat1Meta <= dat1In;
      dat1Sync <= dat1Meta;
    end
  end

  // Line is shared with data, so lows outside the window mean nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cardIrq <= 1'b0;
    end else if (ctrl[CTRL_IRQEN] && intWindow && !dat1Sync) begin
      cardIrq <= 1'b1;
    end else if (wrEn && paddr == OFS_STATUS && pwdata[ST_IRQ]) begin
      cardIrq <= 1'b0;
    end
  end

  // Read wait stalls a multiple read by holding data line 2 low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rwActive <= 1'b0;
    end else begin
      rwActive <= ctrl[CTRL_RWREQ] && ctrl[CTRL_RWCAP] && multiRead && intWindow;
    end
  end
  assign dat2Out = 1'b0;
  assign dat2Oe  = rwActive;

  // Function zero cannot be suspended; slot 8 stands for the memory
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      suspendReq <= '0;
      suspended  <= '0;
    end else begin
      if (wrEn && paddr == OFS_SUSP && pwdata[SUSP_GO]) begin
        suspendReq <= {pwdata[SUSP_MEM], pwdata[7:1]} & ~suspended;
      end else if (suspendAck) begin
        suspendReq <= '0;
      end
      // A confirmation landing with a resume write must not be lost
      if (wrEn && paddr == OFS_SUSP && !pwdata[SUSP_GO]) begin
        suspended <= (suspended & ~{pwdata[SUSP_MEM], pwdata[7:1]}) |
                     (suspendAck ? suspendReq : 8'h00);
      end else if (suspendAck) begin
        suspended <= suspended | suspendReq;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (rdEn) begin
      case (paddr)
        OFS_CTRL:   prdata <= {25'h0000000, ctrl};
        OFS_CMD:    prdata <= {26'h0000000, cmdIndex};
        OFS_STATUS: prdata <= {28'h0000000, rwActive, refused, seq != SEQ_IDLE, cardIrq};
        OFS_SUSP:   prdata <= {23'h000000, suspended[8], suspended[7:1], 1'b0};
        default:    prdata <= '0;
      endcase
    end
  end

  AST_IRQ_WINDOW: assert property (@(posedge clock) disable iff (rst)
    $rose(cardIrq) |-> $past(intWindow) && !$past(dat1Sync))
    else $error("Interrupt caught outside window");
  AST_IRQ_SYNC: assert property (@(posedge clock) disable iff (rst)
    $rose(cardIrq) |-> !$past(dat1In, 3))
    else $error("Interrupt not from a synchronised low");
  AST_IDENT_REFUSED: assert property (@(posedge clock) disable iff (rst)
    cmdWr && seq == SEQ_IDLE && ctrl[CTRL_XFER] && isIdentCmd(reqIndex, reqApp)
    |=> refused && !cmdStart)
    else $error("Identification command in transfer mode");
  AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (rst)
    cmdStart && isIdentCmd(cmdIndex, 1'b0) && seq == SEQ_MAIN |-> openDrain)
    else $error("Identification command not open-drain");
  AST_APP_SEQ: assert property (@(posedge clock) disable iff (rst)
    cmdStart && seq == SEQ_APP |-> cmdIndex == IDX_APP)
    else $error("Application command without APP_CMD");
  AST_SELECT: assert property (@(posedge clock) disable iff (rst)
    cmdWr && seq == SEQ_IDLE && !ctrl[CTRL_SELECT] && needsSelect(reqIndex, reqApp)
    |=> !cmdStart ##1 !cmdStart)
    else $error("Status or general command to unselected card");
  AST_RWAIT: assert property (@(posedge clock) disable iff (rst)
    dat2Oe |-> $past(ctrl[CTRL_RWCAP]) && $past(multiRead) && $past(intWindow))
    else $error("Read wait without capability or window");
  AST_NO_FN0: assert property (@(posedge clock) disable iff (rst)
    wrEn && paddr == OFS_SUSP && pwdata[SUSP_GO] && {pwdata[SUSP_MEM], pwdata[7:1]} == 8'h00
    |=> suspendReq == 8'h00)
    else $error("Function zero alone raised a suspend request");
  AST_RESP1B: assert property (@(posedge clock) disable iff (rst)
    cmdStart && cmdIndex == IDX_GEN && $past(seq) == SEQ_IDLE |-> cmdResp1b)
    else $error("General command without busy response");

  COV_ACMD: cover property (@(posedge clock) disable iff (rst)
    seq == SEQ_APP ##1 cmdDone ##1 cmdStart);
  COV_IRQ: cover property (@(posedge clock) disable iff (rst) $rose(cardIrq));
  COV_RWAIT: cover property (@(posedge clock) disable iff (rst) $rose(dat2Oe));
  COV_SUSP: cover property (@(posedge clock) disable iff (rst) suspendAck && suspendReq != 8'h00);
endmodule // sdh_host_ctrl
`default_nettype wire

// ---- verilog/sdh_pkg.sv ----
// Constants shared by the card-bus host control block
package sdh_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned ID_CLK_KHZ    = 400;
  localparam int unsigned XFER_CLK_MHZ  = 25;
  localparam int unsigned ID_HALF       = (CLK_MHZ * 1000 + 2 * ID_CLK_KHZ - 1) / (2 * ID_CLK_KHZ);
  localparam int unsigned XFER_HALF     = (CLK_MHZ + 2 * XFER_CLK_MHZ - 1) / (2 * XFER_CLK_MHZ);
  localparam int unsigned DIV_W         = 8;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SUSP   = 8'h0C;

  localparam int unsigned CTRL_XFER    = 0;
  localparam int unsigned CTRL_WIDE4   = 1;
  localparam int unsigned CTRL_CLKRUN  = 2;
  localparam int unsigned CTRL_IRQEN   = 3;
  localparam int unsigned CTRL_SELECT  = 4;
  localparam int unsigned CTRL_RWCAP   = 5;
  localparam int unsigned CTRL_RWREQ   = 6;
  localparam logic [6:0]  CTRL_RESET   = 7'h00;

  localparam int unsigned CMD_APP      = 8;
  localparam int unsigned ST_IRQ       = 0;
  localparam int unsigned ST_BUSY      = 1;
  localparam int unsigned ST_REFUSED   = 2;
  localparam int unsigned ST_RWAIT     = 3;
  localparam int unsigned SUSP_GO      = 31;
  localparam int unsigned SUSP_MEM     = 8;

  localparam logic [5:0] IDX_APP      = 6'h37;
  localparam logic [5:0] IDX_STATUS   = 6'h0D;
  localparam logic [5:0] IDX_GEN      = 6'h38;
  localparam logic [5:0] IDX_OPCOND   = 6'h29;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_APP  = 3'b010,
    SEQ_MAIN = 3'b100
  } sdh_seq_t;
endpackage

// ---- verilog/sdh_clk_div.sv ----
// Card bus clock divider with run control
`timescale 1ns/10ps
`default_nettype none
module sdh_clk_div #(
  parameter int unsigned W = sdh_pkg::DIV_W
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] halfCount,
  output logic              cardClk,
  output logic              cardEdge
);
  import sdh_pkg::*;
  logic [W-1:0] cnt;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (!run || cnt >= halfCount - W'(1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  // Stopping holds the line low, so a restart never yields a short pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cardClk <= 1'b0;
    end else if (!run) begin
      cardClk <= 1'b0;
    end else if (cnt >= halfCount - W'(1)) begin
      cardClk <= ~cardClk;
    end
  end

  assign cardEdge = run && (cnt >= halfCount - W'(1)) && !cardClk;
endmodule // sdh_clk_div
`default_nettype wire

// ---- tb/sdh_card_model.sv ----
// Behavioural card on the far side of the host control block
`timescale 1ns/10ps
`default_nettype none
module sdh_card_model #(
  parameter logic [31:0] PROT_SIZE = 32'h0000_1000, // Arbitrary region size
  parameter logic [15:0] CRC_POLY  = 16'h1021
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         cmdStart,
  input  wire logic [5:0]   cmdIndex,
  input  wire logic         intWindow,
  input  wire logic         irqReq,
  input  wire logic [7:0]   suspendReq,
  output logic              cmdDone,
  output logic              suspendAck,
  output logic              dat1In,
  output logic              appFlag,
  output logic              illegal,
  output logic      [527:0] statusOut
);
  import sdh_pkg::*;
  logic [2:0]   cnt;
  logic         busy;
  logic [7:0]   lastReq; // Seven functions plus memory, one slot each
  logic         appNext;
  logic [527:0] statusFrame;
  // One data line, not secured, ordinary memory card
  localparam logic [1:0]   WIDTH_ONE    = 2'b00;
  localparam logic         SECURED      = 1'b0;
  localparam logic [15:0]  MEM_CARD     = 16'h0000;
  localparam logic [511:0] STATUS_BLOCK =
    {WIDTH_ONE, SECURED, 13'h0, MEM_CARD, PROT_SIZE, 448'h0};

  function automatic logic isAcmd(input logic [5:0] idx);
    isAcmd = idx == IDX_STATUS || idx == IDX_OPCOND;
  endfunction

  function automatic logic isStd(input logic [5:0] idx);
    isStd = idx inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h0D, 6'h10, 6'h11,
                        6'h18, 6'h28, 6'h35, IDX_APP, IDX_GEN};
  endfunction

  function automatic logic [15:0] crc16(input logic [511:0] blk);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 511; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ blk[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Block first, check word last
  assign statusFrame = {STATUS_BLOCK, crc16(STATUS_BLOCK)};
  // Held low only while the window is open; pull-up level otherwise
  assign dat1In = (irqReq && intWindow) ? 1'b0 : 1'b1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy    <= 1'b0;
      cnt     <= 3'h0;
      cmdDone <= 1'b0;
    end else begin
      cmdDone <= busy && (cnt == 3'h3);
      cnt     <= busy ? cnt + 3'h1 : 3'h0;
      if (cmdStart)
        busy <= 1'b1;
      else if (cnt == 3'h3)
        busy <= 1'b0;
    end
  end
  // Confirms each new suspension request once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastReq    <= 8'h00;
      suspendAck <= 1'b0;
    end else begin
      lastReq    <= suspendReq;
      suspendAck <= (suspendReq != 8'h00) && (suspendReq != lastReq);
    end
  end
  // Only the command right after APP_CMD may take the overloaded meaning
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      appNext   <= 1'b0;
      appFlag   <= 1'b0;
      illegal   <= 1'b0;
      statusOut <= '0;
    end else if (cmdStart) begin
      appNext <= cmdIndex == IDX_APP;
      appFlag <= cmdIndex == IDX_APP || (appNext && isAcmd(cmdIndex));
      illegal <= !(appNext && isAcmd(cmdIndex)) && !isStd(cmdIndex);
      if (appNext && cmdIndex == IDX_STATUS) begin
        statusOut <= statusFrame;
      end
    end
  end
endmodule // sdh_card_model
`default_nettype wire

// ---- tb/sdh_host_ctrl_test.sv ----
// Self-checking bench for the card bus host control block
`timescale 1ns/10ps
`default_nettype none
module sdh_host_ctrl_test;
  import sdh_pkg::*;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cmdStart, cmdResp1b, cmdDone, dat2Out, dat2Oe, openDrain, cardClk;
  logic intWindow = 0, multiRead = 0, irqReq = 0, dat1In, suspendAck, lastClk, err;
  logic appFlag, illegal;
  logic [527:0] statusOut;
  logic [5:0] cmdIndex;
  logic [7:0] suspendReq;
  logic [5:0] seenIdx[$];
  int errors = 0, check_count = 0, run = 0, halfSeen = 0;
  always #5 clock = ~clock;
  sdh_host_ctrl DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdStart(cmdStart), .cmdIndex(cmdIndex), .cmdResp1b(cmdResp1b), .cmdDone(cmdDone),
    .intWindow(intWindow), .multiRead(multiRead), .dat1In(dat1In), .dat2Out(dat2Out),
    .dat2Oe(dat2Oe), .openDrain(openDrain), .cardClk(cardClk), .suspendReq(suspendReq),
    .suspendAck(suspendAck));
  sdh_card_model card (.clock(clock), .rst(rst), .cmdStart(cmdStart), .cmdIndex(cmdIndex),
    .intWindow(intWindow), .irqReq(irqReq), .suspendReq(suspendReq), .cmdDone(cmdDone),
    .suspendAck(suspendAck), .dat1In(dat1In), .appFlag(appFlag), .illegal(illegal),
    .statusOut(statusOut));
  // Records every command launched and the card clock half period
  always @(posedge clock) begin
    if (cmdStart === 1'b1) seenIdx.push_back(cmdIndex);
    if (cardClk !== lastClk) begin
      halfSeen <= run;
      run <= 1;
    end else run <= run + 1;
    lastClk <= cardClk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task cmd(input logic [31:0] c, input int n);
    seenIdx.delete();
    apb(1, OFS_CMD, c);
    repeat (20) @(posedge clock);
    chk(seenIdx.size(), n);
  endtask
  task t_regs;
    apb(0, OFS_CTRL, 0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    chk(openDrain, 1);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    $display("test regs done");
  endtask
  task t_cmds;
    cmd(32'h10D, 0);
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_REFUSED], 1);
    apb(1, OFS_STATUS, 32'h4);
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_REFUSED], 0);
    apb(1, OFS_CTRL, 32'h10);
    cmd(32'h10D, 2);
    chk({seenIdx[0], seenIdx[1]}, {IDX_APP, IDX_STATUS});
    chk(appFlag, 1'b1);
    chk(statusOut[495:464], 32'h0000_1000);
    chk(statusOut[527:496], 32'h0000_0000);
    seenIdx.delete();
    apb(1, OFS_CMD, 32'h38);
    #1;
    chk({cmdStart, cmdIndex, cmdResp1b}, {1'b1, IDX_GEN, 1'b1});
    repeat (10) @(posedge clock);
    chk({appFlag, illegal}, 2'b00);
    cmd(32'h110, 2);
    chk(appFlag, 1'b0);
    apb(1, OFS_CTRL, 32'h11);
    #1;
    chk(openDrain, 0);
    cmd(32'h0, 0);
    cmd(32'h129, 0);
    cmd(32'h28, 0);
    apb(1, OFS_STATUS, 32'h4);
    $display("test cmds done");
  endtask
  task t_irq;
    apb(1, OFS_CTRL, 32'h19);
    irqReq <= 1;
    repeat (10) @(posedge clock);
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_IRQ], 0);
    intWindow <= 1;
    repeat (5) @(posedge clock);
    intWindow <= 0;
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_IRQ], 1);
    irqReq <= 0;
    apb(1, OFS_STATUS, 32'h1);
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_IRQ], 0);
    $display("test irq done");
  endtask
  task t_susp;
    apb(1, OFS_SUSP, 32'h8000_0103);
    #1;
    chk(suspendReq, 8'h81);
    repeat (6) @(posedge clock);
    chk(suspendReq, 8'h00);
    apb(0, OFS_SUSP, 0);
    chk(rd, 32'h102);
    apb(1, OFS_SUSP, 32'h100);
    apb(0, OFS_SUSP, 0);
    chk(rd, 32'h2);
    apb(1, OFS_SUSP, 32'h8000_0001);
    #1;
    chk(suspendReq, 8'h00);
    $display("test suspend done");
  endtask
  task t_rw;
    apb(1, OFS_CTRL, 32'h73);
    multiRead <= 1;
    repeat (3) @(posedge clock);
    chk(dat2Oe, 0);
    intWindow <= 1;
    repeat (3) @(posedge clock);
    chk({dat2Oe, dat2Out}, 2'b10);
    multiRead <= 0;
    intWindow <= 0;
    repeat (3) @(posedge clock);
    chk(dat2Oe, 0);
    $display("test read wait done");
  endtask
  task t_clk(input logic [31:0] ctl, input int exp);
    apb(1, OFS_CTRL, ctl);
    repeat (600) @(posedge clock);
    chk(halfSeen, exp);
    $display("test clock done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    t_regs;
    t_cmds;
    t_irq;
    t_susp;
    t_rw;
    t_clk(32'h04, ID_HALF);
    t_clk(32'h05, XFER_HALF);
    close_out;
  end
  initial begin
    #200000;
    errors++;
    close_out;
  end
endmodule // sdh_host_ctrl_test
`default_nettype wire
